//--- verilog/dpc_regs.svh
/*
 Named codes, bit positions and reset values of the DDR2 pin interface.
 Assumes inclusion by the package and by the core; definitions only.
*/
`ifndef DPC_REGS_SVH
`define DPC_REGS_SVH

// Command codes on {ras_n, cas_n, we_n} while chip select is low
`define DPC_CMD_MRS 3'h0
`define DPC_CMD_REF 3'h1
`define DPC_CMD_PRE 3'h2
`define DPC_CMD_ACT 3'h3
`define DPC_CMD_WR 3'h4
`define DPC_CMD_RD 3'h5
`define DPC_CMD_RSV 3'h6
`define DPC_CMD_NOP 3'h7

// Mode register choice by bank address
`define DPC_SEL_MR 2'h0
`define DPC_SEL_EMR1 2'h1
`define DPC_SEL_EMR2 2'h2
`define DPC_SEL_EMR3 2'h3

`define DPC_AP_BIT 10
`define DPC_COL_MSB 9
`define DPC_EMR1_DQSN_OFF_BIT 10
`define DPC_EMR1_RDQS_EN_BIT 11
`define DPC_MR_BL_MSB 2
`define DPC_BL8_CODE 3'h3
`define DPC_BEATS_BL4 4'h4
`define DPC_BEATS_BL8 4'h8
`define DPC_MODE_RST 13'h0000

`define DPC_FIFO_DEPTH 8
`define DPC_FIFO_WIDTH 20
`define DPC_SYNC_W 33

`endif

//--- verilog/dpc_pkg.sv
/*
 Types shared by the DDR2 pin interface modules.
 Assumes dpc_regs.svh is on the include path.
*/
package dpc_pkg;
`include "dpc_regs.svh"

typedef enum logic [2:0] {
    DPC_MRS = `DPC_CMD_MRS,
    DPC_REF = `DPC_CMD_REF,
    DPC_PRE = `DPC_CMD_PRE,
    DPC_ACT = `DPC_CMD_ACT,
    DPC_WR = `DPC_CMD_WR,
    DPC_RD = `DPC_CMD_RD,
    DPC_RSV = `DPC_CMD_RSV,
    DPC_NOP = `DPC_CMD_NOP
} dpc_cmd_t;

// Gray sequence idle, preamble, burst, postamble
typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_PRE = 2'h1,
    RD_BURST = 2'h3,
    RD_POST = 2'h2
} dpc_rd_state_t;

endpackage

//--- verilog/dpc_stream_if.sv
/*
 Valid/ready word carrier between the core and its write FIFO.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`include "dpc_regs.svh"
interface dpc_stream_if #(parameter int WIDTH = `DPC_FIFO_WIDTH);
    logic valid;
    logic ready;
    logic [WIDTH-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface

//--- verilog/dpc_fifo.sv
/*
 Synchronous FIFO with valid/ready on both sides.
 Assumes DEPTH is a power of two; one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
`include "dpc_regs.svh"
module dpc_fifo #(
    parameter int WIDTH = `DPC_FIFO_WIDTH,
    parameter int DEPTH = `DPC_FIFO_DEPTH
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    dpc_stream_if.snk s_in,
    dpc_stream_if.src s_out
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL_CNT = (AW + 1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr_reg;
    logic [AW-1:0] rd_ptr_reg;
    logic [AW:0] count_reg;
    logic push;
    logic pop;

    assign s_in.ready = (count_reg != FULL_CNT);
    assign s_out.valid = (count_reg != '0);
    assign s_out.data = mem[rd_ptr_reg];
    assign push = s_in.valid && s_in.ready;
    assign pop = s_out.valid && s_out.ready;

    // Storage carries no reset; only the pointers and count_reg define what is valid
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= s_in.data;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

//--- verilog/dpc_pin_core.sv
/*
 Device-side pin logic of an 8-bit DDR2 SDRAM: command decode, mode
 registers, termination and clock-enable state, read strobes and data,
 write capture with masking into a FIFO.
 Assumes all pin inputs are asynchronous to i_clk (100 MHz) and the pin
 clock is slow enough (125 ns period in the bench) to be oversampled.
*/
// Operation
// RULE_01 - Active, read, write, precharge apply to bank given by bank address.
// RULE_02 - Mode-register command uses bank address to pick the target register.
// RULE_03 - Termination enable follows the registered termination input.
// RULE_04 - Device drives strobe with read data, edges aligned to data.
// RULE_05 - Controller drives strobe centred in write data bits.
// RULE_06 - Complementary strobe used only when extended register 1 bit 10 is zero.
// RULE_07 - Chip select high masks every command.
// RULE_08 - Command decoded from chip select, row, column and write strobes.
// RULE_09 - Write bytes with mask high are not stored.
// RULE_10 - Mask aligned to data, sampled on both strobe edges.
// RULE_11 - Bit 11 of extended register 1 makes mask pin a read strobe.
// RULE_12 - Read strobe enabled disables write masking entirely.
// RULE_13 - Complementary read strobe only with read strobe and differential mode.
// RULE_14 - Address and control sampled at rising clock crossing.
// RULE_15 - Read data timed on both clock crossing directions.
// RULE_16 - Clock enable registered high activates clocking, low deactivates.
// RULE_17 - Row uses A0-A12; column A0-A9, A10 is auto-precharge.
// RULE_18 - Bank address 0,1,2,3 selects base, extended 1, 2, 3.
// RULE_19 - Eight-bit bidirectional data bus, device drives during reads.
`timescale 1ns/100ps
`include "dpc_regs.svh"
module dpc_pin_core (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ck,
    input wire logic i_ck_n,
    input wire logic i_cke,
    input wire logic i_cs_n,
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_we_n,
    input wire logic [1:0] i_ba,
    input wire logic [12:0] i_a,
    input wire logic i_odt,
    input wire logic [7:0] i_dq,
    output logic [7:0] o_dq,
    output logic o_dq_oe,
    input wire logic i_dqs,
    output logic o_dqs,
    output logic o_dqs_oe,
    output logic o_dqs_n,
    output logic o_dqs_n_oe,
    input wire logic i_dm,
    output logic o_rdqs,
    output logic o_rdqs_oe,
    output logic o_rdqs_n,
    output logic o_rdqs_n_oe,
    output logic o_odt_en,
    output logic o_clk_active,
    output logic o_cmd_valid,
    output dpc_pkg::dpc_cmd_t o_cmd,
    output logic [1:0] o_cmd_bank,
    output logic [12:0] o_cmd_addr,
    output logic o_cmd_auto_pre,
    output logic [12:0] o_mr,
    output logic [12:0] o_emr1,
    output logic [12:0] o_emr2,
    output logic [12:0] o_emr3,
    output logic [1:0] o_rd_bank,
    output logic [9:0] o_rd_col,
    input wire logic [7:0] i_rd_data,
    output logic o_wr_valid,
    output logic [1:0] o_wr_bank,
    output logic [9:0] o_wr_col,
    output logic [7:0] o_wr_data,
    input wire logic i_wr_ready,
    output logic o_wr_drop,
    input wire logic i_drop_clr
);
    logic [`DPC_SYNC_W-1:0] sync1_reg;
    logic [`DPC_SYNC_W-1:0] sync2_reg;
    logic ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, dqs_s, dm_s;
    logic [1:0] ba_s;
    logic [12:0] a_s;
    logic [7:0] dq_s;
    logic ck_lvl, ck_lvl_reg, ck_rise, ck_edge;
    logic dqs_prev_reg, dqs_edge;
    logic [2:0] cmd_code;
    logic cmd_taken, cmd_report, is_mrs, is_rd, is_wr;
    logic [3:0] burst_beats;
    logic diff_en, rdqs_en;
    dpc_pkg::dpc_rd_state_t rd_state_reg, rd_state_next;
    logic [3:0] rd_left_reg, rd_left_next;
    logic [1:0] rd_bank_next;
    logic [9:0] rd_col_next;
    logic beat_out;
    logic [7:0] dq_next;
    logic dq_oe_next, dqs_next, dqs_oe_next;
    logic wr_active_reg;
    logic [3:0] wr_left_reg;
    logic [9:0] wr_col_reg;
    logic [1:0] wr_bank_reg;
    logic beat_in, masked, drop;

    dpc_stream_if #(.WIDTH(`DPC_FIFO_WIDTH)) wr_in ();
    dpc_stream_if #(.WIDTH(`DPC_FIFO_WIDTH)) wr_out ();

    // All pins pass two flops; the first stage feeds nothing but the second
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end else begin
            sync1_reg <= {i_ck, i_ck_n, i_cke, i_cs_n, i_ras_n, i_cas_n, i_we_n,
                          i_ba, i_a, i_odt, i_dq, i_dqs, i_dm};
            sync2_reg <= sync1_reg;
        end
    end

    assign {ck_s, ck_n_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s,
            ba_s, a_s, odt_s, dq_s, dqs_s, dm_s} = sync2_reg;

    // Both halves pass the same stages, so the crossing keeps its place
    assign ck_lvl = ck_s & ~ck_n_s;
    assign ck_rise = ck_lvl & ~ck_lvl_reg; // see RULE_14
    assign ck_edge = ck_lvl ^ ck_lvl_reg; // see RULE_15
    assign dqs_edge = dqs_s ^ dqs_prev_reg; // see RULE_10

    assign cmd_code = {ras_n_s, cas_n_s, we_n_s}; // see RULE_08
    assign cmd_taken = ck_rise && cke_s && !cs_n_s; // see RULE_07
    assign cmd_report = cmd_taken && (cmd_code != `DPC_CMD_NOP);
    assign is_mrs = cmd_taken && (cmd_code == `DPC_CMD_MRS);
    assign is_rd = cmd_taken && (cmd_code == `DPC_CMD_RD);
    assign is_wr = cmd_taken && (cmd_code == `DPC_CMD_WR);

    assign burst_beats = (o_mr[`DPC_MR_BL_MSB:0] == `DPC_BL8_CODE) ?
                         `DPC_BEATS_BL8 : `DPC_BEATS_BL4;
    assign diff_en = ~o_emr1[`DPC_EMR1_DQSN_OFF_BIT];
    assign rdqs_en = o_emr1[`DPC_EMR1_RDQS_EN_BIT];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            ck_lvl_reg <= 1'b0;
            dqs_prev_reg <= 1'b0;
        end else begin
            ck_lvl_reg <= ck_lvl;
            dqs_prev_reg <= dqs_s;
        end
    end

    // Termination and clock enable take effect only at a rising crossing
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_odt_en <= 1'b0;
            o_clk_active <= 1'b0;
        end else if (ck_rise) begin
            o_odt_en <= odt_s; // see RULE_03
            o_clk_active <= cke_s; // see RULE_16
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_cmd_valid <= 1'b0;
            o_cmd <= dpc_pkg::DPC_NOP;
            o_cmd_bank <= 2'h0;
            o_cmd_addr <= 13'h0000;
            o_cmd_auto_pre <= 1'b0;
        end else begin
            o_cmd_valid <= cmd_report;
            if (cmd_report) begin
                o_cmd <= dpc_pkg::dpc_cmd_t'(cmd_code);
                o_cmd_bank <= ba_s; // see RULE_01
                o_cmd_addr <= a_s;
                o_cmd_auto_pre <= (is_rd || is_wr) && a_s[`DPC_AP_BIT]; // see RULE_17
            end
        end
    end

    // Undefined after power-up; reset to zero keeps single-ended strobes off
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_mr <= `DPC_MODE_RST;
            o_emr1 <= `DPC_MODE_RST;
            o_emr2 <= `DPC_MODE_RST;
            o_emr3 <= `DPC_MODE_RST;
        end else if (is_mrs) begin
            case (ba_s) // see RULE_02 see RULE_18
                `DPC_SEL_MR: begin
                    o_mr <= a_s;
                end
                `DPC_SEL_EMR1: begin
                    o_emr1 <= a_s;
                end
                `DPC_SEL_EMR2: begin
                    o_emr2 <= a_s;
                end
                default: begin
                    o_emr3 <= a_s;
                end
            endcase
        end
    end

    // Read burst: one beat per clock crossing; reads during a burst are dropped
    always_comb begin
        rd_state_next = rd_state_reg;
        rd_left_next = rd_left_reg;
        rd_bank_next = o_rd_bank;
        rd_col_next = o_rd_col;
        beat_out = 1'b0;
        if (ck_edge) begin
            case (rd_state_reg)
                dpc_pkg::RD_IDLE: begin
                    if (is_rd) begin
                        rd_state_next = dpc_pkg::RD_PRE;
                        rd_left_next = burst_beats;
                        rd_bank_next = ba_s; // see RULE_01
                        rd_col_next = a_s[`DPC_COL_MSB:0]; // see RULE_17
                    end
                end
                dpc_pkg::RD_PRE: begin
                    beat_out = 1'b1;
                    rd_state_next = dpc_pkg::RD_BURST;
                end
                dpc_pkg::RD_BURST: begin
                    if (rd_left_reg != 4'h0) begin
                        beat_out = 1'b1;
                    end else begin
                        rd_state_next = dpc_pkg::RD_POST;
                    end
                end
                default: begin
                    rd_state_next = dpc_pkg::RD_IDLE;
                end
            endcase
        end
        if (beat_out) begin
            rd_left_next = rd_left_reg - 4'h1;
            rd_col_next = o_rd_col + 10'h001;
        end
    end

    assign dq_next = beat_out ? i_rd_data : o_dq; // see RULE_15
    assign dq_oe_next = (rd_state_next == dpc_pkg::RD_BURST); // see RULE_19
    assign dqs_oe_next = (rd_state_next != dpc_pkg::RD_IDLE);
    // Strobe toggles in the same cycle as the data it marks
    assign dqs_next = beat_out ? ~o_dqs :
                      ((rd_state_next == dpc_pkg::RD_BURST) ? o_dqs : 1'b0); // see RULE_04

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rd_state_reg <= dpc_pkg::RD_IDLE;
            rd_left_reg <= 4'h0;
            o_rd_bank <= 2'h0;
            o_rd_col <= 10'h000;
        end else begin
            rd_state_reg <= rd_state_next;
            rd_left_reg <= rd_left_next;
            o_rd_bank <= rd_bank_next;
            o_rd_col <= rd_col_next;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_dq <= 8'h00;
            o_dq_oe <= 1'b0;
            o_dqs <= 1'b0;
            o_dqs_oe <= 1'b0;
            o_dqs_n <= 1'b1;
            o_dqs_n_oe <= 1'b0;
            o_rdqs <= 1'b0;
            o_rdqs_oe <= 1'b0;
            o_rdqs_n <= 1'b1;
            o_rdqs_n_oe <= 1'b0;
        end else begin
            o_dq <= dq_next;
            o_dq_oe <= dq_oe_next;
            o_dqs <= dqs_next;
            o_dqs_oe <= dqs_oe_next;
            o_dqs_n <= ~dqs_next;
            o_dqs_n_oe <= dqs_oe_next && diff_en; // see RULE_06
            o_rdqs <= dqs_next;
            o_rdqs_oe <= dqs_oe_next && rdqs_en; // see RULE_11
            o_rdqs_n <= ~dqs_next;
            o_rdqs_n_oe <= dqs_oe_next && rdqs_en && diff_en; // see RULE_13
        end
    end

    // Write capture relies on the controller centring its strobe in each bit;
    // while the device drives the strobe the input only echoes it
    assign beat_in = wr_active_reg && dqs_edge && !o_dqs_oe; // see RULE_05 see RULE_10
    assign masked = dm_s && !rdqs_en; // see RULE_12
    assign wr_in.valid = beat_in && !masked; // see RULE_09
    assign wr_in.data = {wr_bank_reg, wr_col_reg, dq_s};
    // A stalled FIFO cannot hold back the pins, so the beat is lost and flagged
    assign drop = wr_in.valid && !wr_in.ready;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wr_active_reg <= 1'b0;
            wr_left_reg <= 4'h0;
            wr_col_reg <= 10'h000;
            wr_bank_reg <= 2'h0;
        end else if (is_wr) begin
            wr_active_reg <= 1'b1;
            wr_left_reg <= burst_beats;
            wr_col_reg <= a_s[`DPC_COL_MSB:0]; // see RULE_17
            wr_bank_reg <= ba_s; // see RULE_01
        end else if (beat_in) begin
            wr_left_reg <= wr_left_reg - 4'h1;
            wr_col_reg <= wr_col_reg + 10'h001;
            wr_active_reg <= (wr_left_reg != 4'h1);
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_wr_drop <= 1'b0;
        end else if (drop) begin
            o_wr_drop <= 1'b1;
        end else if (i_drop_clr) begin
            o_wr_drop <= 1'b0;
        end
    end

    dpc_fifo #(
        .WIDTH(`DPC_FIFO_WIDTH),
        .DEPTH(`DPC_FIFO_DEPTH)
    ) u_wr_fifo (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .s_in(wr_in.snk),
        .s_out(wr_out.src)
    );

    assign wr_out.ready = i_wr_ready;
    assign o_wr_valid = wr_out.valid;
    assign {o_wr_bank, o_wr_col, o_wr_data} = wr_out.data;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);

    property p_cs_mask;
        (ck_rise && cs_n_s) |=> !o_cmd_valid;
    endproperty
    a_cs_mask: assert property (p_cs_mask) // see RULE_07
        else $error("Command accepted while chip select high");

    property p_bank_sel;
        cmd_report |=> o_cmd_valid && (o_cmd_bank == $past(ba_s));
    endproperty
    a_bank_sel: assert property (p_bank_sel) // see RULE_01
        else $error("Command bank differs from sampled bank address");

    property p_decode;
        is_rd |=> o_cmd == dpc_pkg::DPC_RD ##1 !o_cmd_valid;
    endproperty
    a_decode: assert property (p_decode) // see RULE_08
        else $error("Read code not decoded as single read");

    property p_emr_sel;
        (is_mrs && ba_s == `DPC_SEL_EMR1) |=> (o_emr1 == $past(a_s)) && $stable(o_mr);
    endproperty
    a_emr_sel: assert property (p_emr_sel) // see RULE_02
        else $error("Extended register 1 not written by its bank code");

    property p_odt;
        ck_rise |=> o_odt_en == $past(odt_s);
    endproperty
    a_odt: assert property (p_odt) // see RULE_03
        else $error("Termination enable not following registered input");

    property p_cke;
        (ck_rise && !cke_s) |=> !o_cmd_valid && !o_clk_active;
    endproperty
    a_cke: assert property (p_cke) // see RULE_16
        else $error("Clock enable low did not stop command handling");

    property p_rd_edge;
        beat_out |=> o_dq_oe && o_dqs_oe && $changed(o_dqs) && (o_dq == $past(i_rd_data));
    endproperty
    a_rd_edge: assert property (p_rd_edge) // see RULE_04
        else $error("Read beat without aligned strobe edge");

    property p_dqsn;
        o_dqs_n_oe |-> !o_emr1[`DPC_EMR1_DQSN_OFF_BIT] && (o_dqs_n == !o_dqs);
    endproperty
    a_dqsn: assert property (p_dqsn) // see RULE_06
        else $error("Complementary strobe driven in single-ended mode");

    property p_rdqsn;
        o_rdqs_n_oe |-> o_rdqs_oe && o_emr1[`DPC_EMR1_RDQS_EN_BIT] &&
                        !o_emr1[`DPC_EMR1_DQSN_OFF_BIT];
    endproperty
    a_rdqsn: assert property (p_rdqsn) // see RULE_13
        else $error("Complementary read strobe driven without both modes");

    property p_mask;
        (beat_in && dm_s && !o_emr1[`DPC_EMR1_RDQS_EN_BIT]) |=> $stable(u_wr_fifo.wr_ptr_reg);
    endproperty
    a_mask: assert property (p_mask) // see RULE_09
        else $error("Masked write byte stored");

    property p_nomask;
        (beat_in && o_emr1[`DPC_EMR1_RDQS_EN_BIT] && wr_in.ready) |=>
            (u_wr_fifo.wr_ptr_reg == $past(u_wr_fifo.wr_ptr_reg) + 1'b1);
    endproperty
    a_nomask: assert property (p_nomask) // see RULE_12
        else $error("Write byte masked while read strobe enabled");

    c_read: cover property (beat_out && rdqs_en);
    c_write: cover property (wr_in.valid && wr_in.ready);
    c_mrs: cover property (is_mrs ##1 o_cmd_valid);
    c_drop: cover property (drop);
endmodule

//--- bench/dpc_ctl_model.sv
/*
 Controller-side pin model: clock, command, address, termination and
 write data, strobe and mask pins of the DDR2 pin core.
 Assumes the bench resolves the shared data, strobe and mask balls.
*/
`timescale 1ns/100ps
module dpc_ctl_model (
    output logic o_ck,
    output logic o_ck_n,
    output logic o_cke,
    output logic o_cs_n,
    output logic [2:0] o_cmd,
    output logic [1:0] o_ba,
    output logic [12:0] o_a,
    output logic o_odt,
    output logic [7:0] o_dq,
    output logic o_dqs,
    output logic o_dm
);
    // Clock stands low between calls
    initial begin
        {o_ck, o_ck_n, o_cke, o_cs_n, o_cmd, o_ba, o_a, o_odt} = {4'h7, 3'h7, 15'h0, 1'b0};
        {o_dq, o_dqs, o_dm} = 10'h0;
    end
    task automatic tick(input int n);
        repeat (n) begin
            #62.5 {o_ck, o_ck_n} = 2'h2;
            #62.5 {o_ck, o_ck_n} = 2'h1;
        end
    endtask
    // Pins change while the clock is low, so the rising crossing sees them stable
    task automatic issue(input logic [2:0] c, input logic [1:0] ba, input logic [12:0] a,
                         input logic cs_n, input logic cke, input logic odt);
        {o_cmd, o_ba, o_a, o_cs_n, o_cke, o_odt} = {c, ba, a, cs_n, cke, odt};
        tick(1);
        {o_cs_n, o_cmd} = 4'hF;
    endtask
    // Data and mask lead each strobe edge by 30 ns and hold 50 ns after it
    task automatic wr_burst(input int n, input logic [7:0] d, input logic [7:0] dm);
        for (int k = 0; k < n; k++) begin
            {o_dq, o_dm} = {d + 8'(k), dm[k]};
            #30 o_dqs = ~o_dqs;
            #50;
        end
        // Released lines show the inverse of their last value, not a stale copy
        {o_dq, o_dm} = ~{o_dq, o_dm};
    endtask
endmodule

//--- bench/dpc_pin_core_tb.sv
/*
 Self-checking bench for dpc_pin_core driven by the controller pin model.
 Assumes the package, header, stream interface and FIFO compile first.
*/
`timescale 1ns/100ps
`include "dpc_regs.svh"
module dpc_pin_core_tb;
    logic i_clk = 1'b0, i_rst_b = 1'b0, i_wr_ready = 1'b0, i_drop_clr = 1'b0;
    logic i_ck, i_ck_n, i_cke, i_cs_n, i_odt, m_dqs, m_dm;
    logic [2:0] pcmd;
    logic [1:0] i_ba, o_cmd_bank, o_rd_bank, o_wr_bank;
    logic [1:0] md = 2'h0;
    logic [12:0] i_a, o_cmd_addr, o_mr, o_emr1, o_emr2, o_emr3;
    logic [7:0] m_dq, o_dq, o_wr_data;
    logic [9:0] o_rd_col, o_wr_col;
    logic o_dq_oe, o_dqs, o_dqs_oe, o_dqs_n, o_dqs_n_oe, o_rdqs, o_rdqs_oe, o_rdqs_n;
    logic o_rdqs_n_oe, o_odt_en, o_clk_active, o_cmd_valid, o_cmd_auto_pre, o_wr_valid;
    logic o_wr_drop;
    dpc_pkg::dpc_cmd_t o_cmd;
    // Shared balls: whoever enables its driver owns the level
    wire [7:0] i_dq = o_dq_oe ? o_dq : m_dq;
    wire i_dqs = o_dqs_oe ? o_dqs : m_dqs;
    wire i_dm = o_rdqs_oe ? o_rdqs : m_dm;
    wire [7:0] i_rd_data = {o_rd_bank, o_rd_col[5:0]};
    wire [51:0] mrs = {o_emr3, o_emr2, o_emr1, o_mr};
    logic [12:0] mv [4] = '{13'h0002, 13'h0386, 13'h1ABC, 13'h0555};
    logic [5:0] rc [4] = '{6'h3B, 6'h09, 6'h1F, 6'h16};
    logic [18:0] cq[$];
    logic [7:0] rq[$];
    int bad_count = 0;
    int n_tests = 0;

    dpc_pin_core uut (
        .i_clk, .i_rst_b, .i_ck, .i_ck_n, .i_cke, .i_cs_n,
        .i_ras_n(pcmd[2]), .i_cas_n(pcmd[1]), .i_we_n(pcmd[0]), .i_ba, .i_a, .i_odt,
        .i_dq, .o_dq, .o_dq_oe, .i_dqs, .o_dqs, .o_dqs_oe, .o_dqs_n, .o_dqs_n_oe, .i_dm,
        .o_rdqs, .o_rdqs_oe, .o_rdqs_n, .o_rdqs_n_oe, .o_odt_en, .o_clk_active,
        .o_cmd_valid, .o_cmd, .o_cmd_bank, .o_cmd_addr, .o_cmd_auto_pre, .o_mr, .o_emr1,
        .o_emr2, .o_emr3, .o_rd_bank, .o_rd_col, .i_rd_data, .o_wr_valid, .o_wr_bank,
        .o_wr_col, .o_wr_data, .i_wr_ready, .o_wr_drop, .i_drop_clr
    );
    dpc_ctl_model ctl (
        .o_ck(i_ck), .o_ck_n(i_ck_n), .o_cke(i_cke), .o_cs_n(i_cs_n), .o_cmd(pcmd),
        .o_ba(i_ba), .o_a(i_a), .o_odt(i_odt), .o_dq(m_dq), .o_dqs(m_dqs), .o_dm(m_dm)
    );

    always #5 i_clk = ~i_clk;
    always @(posedge i_clk) if (o_cmd_valid === 1'b1) begin
        cq.push_back({o_cmd, o_cmd_bank, o_cmd_addr, o_cmd_auto_pre});
    end
    // Let the strobe edge's own updates land before sampling the beat
    always @(o_dqs) begin
        #1;
        if (o_dq_oe === 1'b1) begin
            rq.push_back(o_dq);
            chk({o_dqs_n_oe, o_rdqs_oe, o_rdqs_n_oe, o_dqs_n_oe & (o_dqs_n ^ o_dqs),
                 o_rdqs_oe & (o_rdqs ~^ o_dqs), o_rdqs_n_oe & (o_rdqs_n ^ o_dqs)},
                {2{!md[0], md[1], md[1] & !md[0]}}, "strobes");
        end
    end

    task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic done(input string s);
        $display("test %s finished", s);
    endtask
    task automatic setm(input logic [1:0] m);
        ctl.issue(`DPC_CMD_MRS, 2'h1, 13'(m) << 10, 1'b0, 1'b1, 1'b0);
        md = m;
    endtask
    task automatic rd_test(input int n);
        rq.delete();
        ctl.issue(`DPC_CMD_RD, 2'h2, 13'h0010, 1'b0, 1'b1, 1'b0);
        ctl.tick(n / 2 + 2);
        chk(24'(rq.size()), 24'(n), "beats");
        foreach (rq[k])
            chk(rq[k], {2'h2, 6'h10 + 6'(k)}, "rd data");
        chk({o_dq_oe, o_dqs_oe}, 2'h0, "rd release");
    endtask
    task automatic pop(input logic [19:0] e);
        int k;
        @(posedge i_clk) #1;
        for (k = 0; k < 50 && o_wr_valid !== 1'b1; k++)
            @(posedge i_clk) #1;
        if (k == 50) begin
            bad_count++;
            stop_test();
        end
        chk({o_wr_bank, o_wr_col, o_wr_data}, e, "wr entry");
        i_wr_ready = 1'b1;
        @(posedge i_clk) #1;
        i_wr_ready = 1'b0;
    endtask
    task automatic wr(input logic [7:0] d, input logic [7:0] dm, input int n);
        ctl.issue(`DPC_CMD_WR, 2'h1, 13'h0020, 1'b0, 1'b1, 1'b0);
        ctl.wr_burst(n, d, dm);
    endtask
    task automatic drain(input logic [7:0] dm, input int n);
        for (int k = 0; k < n; k++)
            if (!dm[k] || md[1])
                pop({2'h1, 10'h020 + 10'(k), 8'h5A + 8'(k)});
        chk(o_wr_valid, 1'b0, "fifo empty");
    endtask

    initial begin
        #200000;
        bad_count++;
        stop_test();
    end
    initial begin
        repeat (5) @(posedge i_clk);
        #1 i_rst_b = 1'b1;
        repeat (4) @(posedge i_clk) #1;
        chk({o_dq_oe, o_dqs_oe, o_dqs_n_oe, o_rdqs_oe, o_cmd, o_wr_valid}, 8'h0E,
            "reset");
        for (int i = 0; i < 4; i++)
            ctl.issue(`DPC_CMD_MRS, 2'(i), mv[i], 1'b0, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++)
            chk(mrs[13*i +: 13], mv[i], "mode reg");
        done("mode");
        for (int c = 1; c < 8; c++) begin
            cq.delete();
            ctl.issue(3'(c), 2'(c), 13'h1400 | 13'(c), 1'b0, 1'b1, 1'b0);
            chk(24'(cq.size()), 24'(c != 7), "cmd count");
            if (c != 7)
                chk(cq[0], {3'(c), 2'(c), 13'h1400 | 13'(c), 1'(c == 4 || c == 5)},
                    "cmd fields");
        end
        foreach (rc[i]) begin
            cq.delete();
            ctl.issue(`DPC_CMD_ACT, 2'h3, 13'h0100, rc[i][5], rc[i][4], rc[i][3]);
            chk({o_clk_active, o_odt_en, cq.size() != 0}, {rc[i][1:0], rc[i][2]}, "gating");
        end
        done("decode");
        for (int m = 0; m < 4; m++) begin
            setm(2'(m));
            rd_test(4);
        end
        done("read");
        setm(2'h0);
        wr(8'h5A, 8'h02, 4);
        drain(8'h02, 4);
        setm(2'h2);
        wr(8'h5A, 8'h02, 4);
        drain(8'h02, 4);
        setm(2'h0);
        ctl.issue(`DPC_CMD_MRS, 2'h0, 13'h0003, 1'b0, 1'b1, 1'b0);
        wr(8'h5A, 8'h00, 8);
        chk(o_wr_drop, 1'b0, "no drop");
        wr(8'hC0, 8'h00, 8);
        chk(o_wr_drop, 1'b1, "drop set");
        drain(8'h00, 8);
        @(posedge i_clk) #1 i_drop_clr = 1'b1;
        @(posedge i_clk) #1 i_drop_clr = 1'b0;
        @(posedge i_clk) #1;
        chk(o_wr_drop, 1'b0, "drop clear");
        done("write");
        rd_test(8);
        done("burst8");
        stop_test();
    end
endmodule
